// ---- dscb_pkg.sv ----
/*
 * Constants of the converter configuration register bank.
 * Assumes a 100 MHz core clock and a 16-bit serial instruction.
 */
// Contract
// - Writing restart bit one starts soft reset
// - Restart bit clears itself after soft reset
// - Step bit one: address rises per byte
// - Step bit zero (reset): address falls
// - Bit order select: one LSB first
// - Read-only part class code register
// - Scratch byte affects no device function
// - Scratch byte reads back written value
// - Scratch byte returns to zero on reset
// - Reference shutdown bit, reset zero
// - Channel-0 shutdown bit, reset one
package dscb_pkg;
    localparam int          ADDR_W          = 15;
    // Register offsets
    localparam logic [14:0] OFS_CFG         = 15'h0000;
    localparam logic [14:0] OFS_CLASS       = 15'h0003;
    localparam logic [14:0] OFS_ID_LOW      = 15'h0004;
    localparam logic [14:0] OFS_ID_HIGH     = 15'h0005;
    localparam logic [14:0] OFS_GRADE       = 15'h0006;
    localparam logic [14:0] OFS_PAGE        = 15'h0008;
    localparam logic [14:0] OFS_SCRATCH     = 15'h000a;
    localparam logic [14:0] OFS_PWR0        = 15'h0011;
    // Interface config field positions
    localparam int          CFG_RESTART     = 0;
    localparam int          CFG_ORDER       = 1;
    localparam int          CFG_STEP        = 2;
    localparam int          CFG_PIN_SEL     = 3;
    // Power control field positions
    localparam int          PWR_REF_BIT     = 7;
    localparam int          PWR_CH0_BIT     = 6;
    // Reset values
    localparam logic [3:0]  CFG_RST         = 4'h0;
    localparam logic [1:0]  PAGE_RST        = 2'h3;
    localparam logic [7:0]  SCRATCH_RST     = 8'h00;
    localparam logic        REF_SD_RST      = 1'b0;
    localparam logic        CH0_SD_RST      = 1'b1;
    // Soft reset duration
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          SOFT_RST_NS     = 40;
    localparam logic [3:0]  SOFT_RST_CYC    =
        4'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Serial engine phases
    typedef enum logic [0:0]
    {
        ENG_INSTR = 1'b0,
        ENG_DATA  = 1'b1
    } dscb_phase_t;
endpackage : dscb_pkg

// ---- dscb_serial_engine.sv ----
/*
 * Serial transfer engine: instruction, address stepping, byte shifting.
 * Assumes synchronised inputs and a serial clock at most core_clk / 8.
 */
`timescale 1ns/100ps
module dscb_serial_engine
(
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    input  wire logic                      sclk_s,
    input  wire logic                      cs_n_s,
    input  wire logic                      din_s,
    input  wire logic                      lsb_first,
    input  wire logic                      step_up,
    input  wire logic [7:0]                rd_data,
    output logic                           wr_stb_r,
    output logic [dscb_pkg::ADDR_W-1:0]    wr_addr_r,
    output logic [7:0]                     wr_data_r,
    output logic [dscb_pkg::ADDR_W-1:0]    addr_r,
    output logic                           dout_r,
    output logic                           drive_r
);
    import dscb_pkg::*;

    dscb_phase_t         state_r, state_nxt;  // Transfer phase
    logic [3:0]          cnt_r, cnt_nxt;      // Rising edges in phase
    logic [14:0]         sh_r, sh_nxt;        // Instruction shifter
    logic [7:0]          byte_r, byte_nxt;    // Incoming data byte
    logic [7:0]          out_r, out_nxt;      // Outgoing data byte
    logic [2:0]          ocnt_r, ocnt_nxt;    // Outgoing bit index
    logic                rnw_r, rnw_nxt;      // Read transfer
    logic                load_r, load_nxt;    // Fetch byte next cycle
    logic                sclk_d_r, sclk_d_nxt;
    logic                wr_stb_nxt, dout_nxt, drive_nxt;
    logic [14:0]         addr_nxt, wr_addr_nxt;
    logic [7:0]          wr_data_nxt;
    logic                rise, fall;

    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;

    // Next-state of the transfer; edges are rare, so a fetch never
    // coincides with one at the supported serial clock rate
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        sh_nxt      = sh_r;
        byte_nxt    = byte_r;
        out_nxt     = out_r;
        ocnt_nxt    = ocnt_r;
        rnw_nxt     = rnw_r;
        load_nxt    = 1'b0;
        sclk_d_nxt  = sclk_s;
        wr_stb_nxt  = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        addr_nxt    = addr_r;
        dout_nxt    = dout_r;
        drive_nxt   = drive_r;
        if (load_r)
        begin
            out_nxt  = rd_data;
            ocnt_nxt = 3'h0;
        end
        if (cs_n_s)
        begin
            // Frame over: back to instruction
            state_nxt = ENG_INSTR;
            cnt_nxt   = 4'h0;
            drive_nxt = 1'b0;
        end
        else if (rise)
        begin
            case (state_r)
                ENG_INSTR:
                begin
                    sh_nxt  = {sh_r[13:0], din_s};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == 4'hf)
                    begin
                        rnw_nxt   = sh_r[14];
                        addr_nxt  = {sh_r[13:0], din_s};
                        state_nxt = ENG_DATA;
                        cnt_nxt   = 4'h0;
                        load_nxt  = sh_r[14];
                    end
                end
                ENG_DATA:
                begin
                    // Data bit order
                    byte_nxt = lsb_first ? {din_s, byte_r[7:1]}
                                         : {byte_r[6:0], din_s};
                    cnt_nxt  = cnt_r + 4'h1;
                    if (cnt_r == 4'h7)
                    begin
                        cnt_nxt     = 4'h0;
                        wr_stb_nxt  = ~rnw_r;
                        wr_addr_nxt = addr_r;
                        wr_data_nxt = byte_nxt;
                        load_nxt    = rnw_r;
                        // Step up or down
                        addr_nxt    = step_up ? addr_r + 15'h0001
                                              : addr_r - 15'h0001;
                    end
                end
                default:
                    state_nxt = ENG_INSTR;
            endcase
        end
        else if (fall && state_r == ENG_DATA && rnw_r)
        begin
            // Outgoing bit order follows the same select
            dout_nxt  = lsb_first ? out_r[ocnt_r] : out_r[3'h7 - ocnt_r];
            ocnt_nxt  = ocnt_r + 3'h1;
            drive_nxt = 1'b1;
        end
    end

    // Registers of the engine
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r   <= ENG_INSTR;
            cnt_r     <= 4'h0;
            sh_r      <= 15'h0000;
            byte_r    <= 8'h00;
            out_r     <= 8'h00;
            ocnt_r    <= 3'h0;
            rnw_r     <= 1'b0;
            load_r    <= 1'b0;
            sclk_d_r  <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_addr_r <= 15'h0000;
            wr_data_r <= 8'h00;
            addr_r    <= 15'h0000;
            dout_r    <= 1'b0;
            drive_r   <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            sh_r      <= sh_nxt;
            byte_r    <= byte_nxt;
            out_r     <= out_nxt;
            ocnt_r    <= ocnt_nxt;
            rnw_r     <= rnw_nxt;
            load_r    <= load_nxt;
            sclk_d_r  <= sclk_d_nxt;
            wr_stb_r  <= wr_stb_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            addr_r    <= addr_nxt;
            dout_r    <= dout_nxt;
            drive_r   <= drive_nxt;
        end
    end

    // Address stepping checks
    step_up_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (rise && !cs_n_s && state_r == ENG_DATA && cnt_r == 4'h7 && step_up)
        |=> addr_r == $past(addr_r) + 15'h0001)
        else $error("address did not step up");
    step_down_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (rise && !cs_n_s && state_r == ENG_DATA && cnt_r == 4'h7
         && !step_up)
        |=> addr_r == $past(addr_r) - 15'h0001)
        else $error("address did not step down");
endmodule : dscb_serial_engine

// ---- dscb_bank.sv ----
/*
 * Configuration register bank reached over the serial port.
 * Assumes host holds each serial clock level for at least 4 core clocks.
 */
`timescale 1ns/100ps
module dscb_bank
#(
    parameter logic [7:0] PART_CLASS = 8'h3c,  // Arbitrary value
    parameter logic [7:0] ID_LOW     = 8'h5a,  // Arbitrary value
    parameter logic [7:0] ID_HIGH    = 8'ha5,  // Arbitrary value
    parameter logic [3:0] GRADE      = 4'h2,   // Arbitrary value
    parameter logic [3:0] REVISION   = 4'h1    // Arbitrary value
)
(
    input  wire logic  core_clk,
    input  wire logic  reset_n,
    input  wire logic  spi_sclk,
    input  wire logic  spi_cs_n,
    input  wire logic  spi_sdio_in,
    output logic       spi_sdio_out_r,
    output logic       spi_sdio_oe_n_r,
    output logic       spi_sdo_out_r,
    output logic       spi_sdo_oe_n_r,
    output logic       reference_shutdown_r,
    output logic       channel0_shutdown_r,
    output logic [1:0] channel_page_r,
    output logic       soft_reset_busy_r
);
    import dscb_pkg::*;

    logic [2:0]  sync1_r, sync2_r;   // Pin synchronisers
    logic [3:0]  cfg_r, cfg_nxt;     // Interface control bits
    logic [1:0]  page_nxt;
    logic [7:0]  scratch_r, scratch_nxt;
    logic        ref_nxt, ch0_nxt;
    logic [3:0]  srst_cnt_r, srst_cnt_nxt;
    logic        busy_nxt;
    logic [7:0]  rd_data;            // Read mux to engine
    logic        wr_stb, dout, drive;
    logic [14:0] wr_addr, addr;
    logic [7:0]  wr_data;
    logic        sdio_o_nxt, sdio_oe_nxt, sdo_o_nxt, sdo_oe_nxt;

    // Two flops per pin; only stage two is read by logic
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_r <= 3'h2;
            sync2_r <= 3'h2;
        end
        else
        begin
            sync1_r <= {spi_sdio_in, spi_cs_n, spi_sclk};
            sync2_r <= sync1_r;
        end
    end

    // Serial transfer engine
    dscb_serial_engine u_engine
    (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .sclk_s    (sync2_r[0]),
        .cs_n_s    (sync2_r[1]),
        .din_s     (sync2_r[2]),
        .lsb_first (cfg_r[CFG_ORDER]),
        .step_up   (cfg_r[CFG_STEP]),
        .rd_data   (rd_data),
        .wr_stb_r  (wr_stb),
        .wr_addr_r (wr_addr),
        .wr_data_r (wr_data),
        .addr_r    (addr),
        .dout_r    (dout),
        .drive_r   (drive)
    );

    // Read mux; unmapped and reserved bits read zero
    always_comb
    begin
        case (addr)
            // Upper nibble mirrors lower, bit-reversed
            OFS_CFG:     rd_data = {cfg_r[0], cfg_r[1], cfg_r[2], cfg_r[3],
                                    cfg_r};
            OFS_CLASS:   rd_data = PART_CLASS;
            OFS_ID_LOW:  rd_data = ID_LOW;
            OFS_ID_HIGH: rd_data = ID_HIGH;
            OFS_GRADE:   rd_data = {GRADE, REVISION};
            OFS_PAGE:    rd_data = {6'h00, channel_page_r};
            // Scratch only feeds this mux, nothing else
            OFS_SCRATCH: rd_data = scratch_r;
            OFS_PWR0:    rd_data = {reference_shutdown_r,
                                    channel0_shutdown_r, 6'h00};
            default:     rd_data = 8'h00;
        endcase
    end

    // Register writes; soft reset overrides any write while it runs
    always_comb
    begin
        cfg_nxt      = cfg_r;
        page_nxt     = channel_page_r;
        scratch_nxt  = scratch_r;
        ref_nxt      = reference_shutdown_r;
        ch0_nxt      = channel0_shutdown_r;
        srst_cnt_nxt = srst_cnt_r;
        if (srst_cnt_r != 4'h0)
        begin
            // Defaults held; restart bit drops on the last cycle
            srst_cnt_nxt = srst_cnt_r - 4'h1;
            cfg_nxt      = CFG_RST | {3'h0, srst_cnt_r != 4'h1};
            page_nxt     = PAGE_RST;
            scratch_nxt  = SCRATCH_RST;
            ref_nxt      = REF_SD_RST;
            ch0_nxt      = CH0_SD_RST;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                OFS_CFG:
                begin
                    cfg_nxt = wr_data[3:0];
                    if (wr_data[CFG_RESTART])
                        srst_cnt_nxt = SOFT_RST_CYC;
                end
                OFS_PAGE:    page_nxt    = wr_data[1:0];
                OFS_SCRATCH: scratch_nxt = wr_data;
                OFS_PWR0:
                begin
                    ref_nxt = wr_data[PWR_REF_BIT];
                    ch0_nxt = wr_data[PWR_CH0_BIT];
                end
                default:     cfg_nxt = cfg_r; // Read-only or unmapped
            endcase
        end
        busy_nxt = srst_cnt_nxt != 4'h0;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_r                <= CFG_RST;
            channel_page_r       <= PAGE_RST;
            scratch_r            <= SCRATCH_RST;
            reference_shutdown_r <= REF_SD_RST;
            channel0_shutdown_r  <= CH0_SD_RST;
            srst_cnt_r           <= 4'h0;
            soft_reset_busy_r    <= 1'b0;
        end
        else
        begin
            cfg_r                <= cfg_nxt;
            channel_page_r       <= page_nxt;
            scratch_r            <= scratch_nxt;
            reference_shutdown_r <= ref_nxt;
            channel0_shutdown_r  <= ch0_nxt;
            srst_cnt_r           <= srst_cnt_nxt;
            soft_reset_busy_r    <= busy_nxt;
        end
    end

    // Output pin steering: pin select one sends read data on spi_sdo
    always_comb
    begin
        sdio_o_nxt  = dout & ~cfg_r[CFG_PIN_SEL];
        sdio_oe_nxt = ~(drive & ~cfg_r[CFG_PIN_SEL]);
        sdo_o_nxt   = dout & cfg_r[CFG_PIN_SEL];
        sdo_oe_nxt  = ~(drive & cfg_r[CFG_PIN_SEL]);
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            spi_sdio_out_r  <= 1'b0;
            spi_sdio_oe_n_r <= 1'b1;
            spi_sdo_out_r   <= 1'b0;
            spi_sdo_oe_n_r  <= 1'b1;
        end
        else
        begin
            spi_sdio_out_r  <= sdio_o_nxt;
            spi_sdio_oe_n_r <= sdio_oe_nxt;
            spi_sdo_out_r   <= sdo_o_nxt;
            spi_sdo_oe_n_r  <= sdo_oe_nxt;
        end
    end

    // Checks
    restart_start_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (wr_stb && wr_addr == OFS_CFG && wr_data[0] && srst_cnt_r == 4'h0)
        |=> soft_reset_busy_r && cfg_r[0])
        else $error("restart write did not start soft reset");
    restart_clear_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $rose(soft_reset_busy_r) |-> ##[1:5] !cfg_r[0])
        else $error("restart bit did not clear itself");
    mirror_read_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        addr == OFS_CFG |-> rd_data[7:4] ==
            {rd_data[0], rd_data[1], rd_data[2], rd_data[3]})
        else $error("config mirror bits disagree");
    class_read_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        addr == OFS_CLASS |-> rd_data == PART_CLASS)
        else $error("part class code wrong");
    scratch_hold_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (wr_stb && wr_addr == OFS_SCRATCH && srst_cnt_r == 4'h0)
        |=> scratch_r == $past(wr_data) ##1
            (scratch_r == $past(scratch_r) || soft_reset_busy_r
             || $past(wr_stb)))
        else $error("scratch byte not retained");
    scratch_clear_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $fell(soft_reset_busy_r) |-> scratch_r == 8'h00)
        else $error("scratch byte not cleared by soft reset");
    ref_default_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $fell(soft_reset_busy_r) |-> !reference_shutdown_r)
        else $error("reference shutdown default wrong");
    ch0_default_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $fell(soft_reset_busy_r)
        |-> channel0_shutdown_r && channel_page_r == 2'h3)
        else $error("channel defaults wrong after soft reset");
endmodule : dscb_bank

// ---- dscb_host_model.sv ----
/*
 * Serial host model that drives the bank's serial pins.
 * Assumes core_clk is free running; it paces the serial clock from it.
 */
`timescale 1ns/100ps
module dscb_host_model
(
    input  wire logic core_clk,
    input  wire logic spi_sdio_out_r,
    input  wire logic spi_sdio_oe_n_r,
    input  wire logic spi_sdo_out_r,
    input  wire logic spi_sdo_oe_n_r,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_sdio_in
);
    logic [7:0] wbuf [4];  // Bytes to send
    logic [7:0] rbuf [4];  // Bytes received
    logic       drv;       // Host drives the shared data pin
    logic       hv;        // Host data value
    logic       flip;      // Toggles per bit, stands for a floating pin
    logic       sdo_w;     // Level on the separate output pin

    // Wire levels; a released pin must not hold its last value
    assign spi_sdio_in = !spi_sdio_oe_n_r ? spi_sdio_out_r
                                          : (drv ? hv : flip);
    assign sdo_w       = !spi_sdo_oe_n_r ? spi_sdo_out_r : flip;

    // Idle: clock low and still, chip deselected
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        drv      = 1'b1;
        hv       = 1'b0;
        flip     = 1'b0;
    end

    // One bit: low phase with data set up, then sample on the rise
    task automatic clk_bit(input logic d, input logic sel, output logic q);
        @(negedge core_clk);
        spi_sclk = 1'b0;
        hv       = d;
        flip     = ~flip;
        repeat (6) @(negedge core_clk);
        spi_sclk = 1'b1;
        q        = sel ? sdo_w : spi_sdio_in;
        repeat (4) @(negedge core_clk);
    endtask : clk_bit

    // Whole frame: instruction always MSB first, data in chosen order
    task automatic xfer(input logic rd, input logic [14:0] addr,
                        input int n, input logic lsb, input logic sel);
        logic        q;
        logic [15:0] ins;
        logic [7:0]  b;
        ins = {rd, addr};
        @(negedge core_clk);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
            clk_bit(ins[i], sel, q);
        drv = !rd;  // Release the data pin for reads
        for (int k = 0; k < n; k++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                clk_bit(wbuf[k][lsb ? i : 7 - i], sel, q);
                b[lsb ? i : 7 - i] = q;
            end
            rbuf[k] = b;
        end
        @(negedge core_clk);
        spi_sclk = 1'b0;
        repeat (2) @(negedge core_clk);
        spi_cs_n = 1'b1;
        drv      = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask : xfer
endmodule : dscb_host_model

// ---- testbench.sv ----
/*
 * Self-checking bench for the configuration register bank.
 * Assumes the host model paces all serial traffic.
 */
`timescale 1ns/100ps
module testbench;
    import dscb_pkg::*;
    logic       core_clk;
    logic       reset_n;
    wire        sclk, cs_n, sdio_in, sdio_o, sdio_oe_n, sdo_o, sdo_oe_n;
    wire        ref_sd, ch0_sd, busy;
    wire  [1:0] page;
    wire  [7:0] pins;           // Control outputs gathered in one word
    int         fails, checked, cycles;
    logic       seen_busy = 1'b0;
    logic [3:0] cfg_lo;         // Expected lower config bits
    logic [7:0] d;

    assign pins = {4'h0, ref_sd, ch0_sd, page};

    dscb_bank dscb_bank_inst
    (
        .core_clk(core_clk), .reset_n(reset_n), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_sdio_in(sdio_in), .spi_sdio_out_r(sdio_o),
        .spi_sdio_oe_n_r(sdio_oe_n), .spi_sdo_out_r(sdo_o),
        .spi_sdo_oe_n_r(sdo_oe_n), .reference_shutdown_r(ref_sd),
        .channel0_shutdown_r(ch0_sd), .channel_page_r(page),
        .soft_reset_busy_r(busy)
    );

    dscb_host_model dscb_host_model_inst
    (
        .core_clk(core_clk), .spi_sdio_out_r(sdio_o),
        .spi_sdio_oe_n_r(sdio_oe_n), .spi_sdo_out_r(sdo_o),
        .spi_sdo_oe_n_r(sdo_oe_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_sdio_in(sdio_in)
    );

    // 100 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Expected config byte: upper nibble mirrors lower, reversed
    function automatic logic [7:0] cfg_exp(input logic [3:0] lo);
        return {lo[0], lo[1], lo[2], lo[3], lo};
    endfunction : cfg_exp

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // Single-byte writes and n-byte reads in the order and pin the bank is set for
    task automatic wr1(input logic [14:0] a, input logic [7:0] x);
        dscb_host_model_inst.wbuf[0] = x;
        dscb_host_model_inst.xfer(1'b0, a, 1, cfg_lo[1], cfg_lo[3]);
    endtask : wr1

    task automatic rdn(input logic [14:0] a, input int n);
        dscb_host_model_inst.xfer(1'b1, a, n, cfg_lo[1], cfg_lo[3]);
    endtask : rdn

    // Soft reset is short; catch it whenever it shows
    always @(posedge core_clk)
        if (busy === 1'b1)
            seen_busy <= 1'b1;

    // Cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            report_and_stop;
        end
    end

    initial
    begin
        reset_n = 1'b0;
        cfg_lo  = 4'h0;
        void'($urandom(90145));
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        check(pins, 8'h07);
        rdn(OFS_CFG, 1);
        check(dscb_host_model_inst.rbuf[0], cfg_exp(4'h0));
        wr1(OFS_CLASS, 8'h00);
        rdn(OFS_CLASS, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h3c);
        rdn(15'h0007, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h00);
        $display("test reset_and_ids done");
        for (int i = 0; i < 5; i++)
        begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            wr1(OFS_SCRATCH, d);
            rdn(OFS_SCRATCH, 1);
            check(dscb_host_model_inst.rbuf[0], d);
            check(pins, 8'h07);
        end
        $display("test scratch done");
        d = 8'($urandom);
        dscb_host_model_inst.wbuf[0] = d;
        dscb_host_model_inst.wbuf[1] = 8'h11;
        dscb_host_model_inst.wbuf[2] = 8'h01;
        dscb_host_model_inst.xfer(1'b0, OFS_SCRATCH, 3, 1'b0, 1'b0);
        check(pins, 8'h05);
        wr1(OFS_CFG, 8'h04);
        cfg_lo = 4'h4;
        rdn(OFS_CLASS, 3);
        check(dscb_host_model_inst.rbuf[0], 8'h3c);
        check(dscb_host_model_inst.rbuf[1], 8'h5a);
        check(dscb_host_model_inst.rbuf[2], 8'ha5);
        dscb_host_model_inst.wbuf[0] = 8'h02;
        dscb_host_model_inst.wbuf[2] = 8'h3e;
        dscb_host_model_inst.xfer(1'b0, OFS_PAGE, 3, 1'b0, 1'b0);
        check(pins, 8'h06);
        rdn(OFS_SCRATCH, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h3e);
        $display("test stepping done");
        wr1(OFS_CFG, 8'h06);
        cfg_lo = 4'h6;
        rdn(OFS_CFG, 1);
        check(dscb_host_model_inst.rbuf[0], cfg_exp(4'h6));
        d = 8'($urandom) | 8'h01;
        wr1(OFS_SCRATCH, d);
        rdn(OFS_SCRATCH, 1);
        check(dscb_host_model_inst.rbuf[0], d);
        wr1(OFS_CFG, 8'h0e);
        cfg_lo = 4'he;
        rdn(OFS_CFG, 1);
        check(dscb_host_model_inst.rbuf[0], cfg_exp(4'he));
        $display("test order_and_pin done");
        wr1(OFS_PWR0, 8'h80);
        check(pins, 8'h0a);
        rdn(OFS_PWR0, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h80);
        $display("test power done");
        wr1(OFS_CFG, 8'h0f);
        cfg_lo = 4'h0;
        check(8'(seen_busy), 8'h01);
        check(8'(busy), 8'h00);
        check(pins, 8'h07);
        rdn(OFS_CFG, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h00);
        rdn(OFS_SCRATCH, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h00);
        $display("test soft_reset done");
        wr1(OFS_SCRATCH, 8'($urandom) | 8'h80);
        @(negedge core_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        rdn(OFS_SCRATCH, 1);
        check(dscb_host_model_inst.rbuf[0], 8'h00);
        $display("test hard_reset done");
        report_and_stop;
    end
endmodule : testbench
